// file: debug_engine_map.vh
`ifndef DEBUG_ENGINE_MAP_VH
`define DEBUG_ENGINE_MAP_VH
// Command bytes
`define CMD_WR_CNTR 8'h01
`define CMD_RD_STAT 8'h02
`define CMD_WR_CTRL 8'h04
`define CMD_RD_CTRL 8'h05
`define CMD_WR_REG 8'h08
`define CMD_RD_REG 8'h09
`define CMD_WR_PMEM 8'h0A
`define CMD_RD_PMEM 8'h0B
`define CMD_WR_DMEM 8'h0C
`define CMD_RD_DMEM 8'h0D
`define CMD_CRC 8'h0E
`define CMD_STEP 8'h10
`define CMD_STUFF 8'h11
`define CMD_EXEC 8'h12
`define CMD_RD_BAUD 8'h1B
// Control register fields
`define CTL_HALT 7
`define CTL_BRK_EN 6
`define CTL_ACK_EN 5
`define CTL_SPIN 4
`define CTL_PC_BRK 3
`define CTL_ZERO_BRK 2
`define CTL_RESET 0
`define CTL_RESET_VAL 8'h00
// Status register fields
`define STAT_IDLE 7
`define STAT_LOWPWR 6
`define STAT_LOCK 5
// Constant answers
`define FILL_BYTE 8'hFF
`define ACK_BYTE 8'hFF
`define BREAK_OPCODE 8'h00
`define CRC_PRESET 16'hFFFF
`define CRC_POLY_REFL 16'h8408
`define BAUD_FIELD_W 12
`define PMEM_LAST 16'hFFFF
`endif

// file: byte_buffer.v
`timescale 1ns/100ps
`default_nettype none
module byte_buffer (
  input wire sys_clk,
  input wire nrst,
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem [0:1];
  reg [1:0] count;
  reg rd_ptr;
  reg wr_ptr;
  wire push;
  wire pop;
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      count <= 2'd0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      mem[0] <= 8'h00;
      mem[1] <= 8'h00;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      if (push && !pop)
        count <= count + 2'd1;
      else if (pop && !push)
        count <= count - 2'd1;
    end
  end
endmodule
`default_nettype wire

// file: debug_command_engine.v
// Behaviour
// - Register read 1-256 bytes, FFh when blocked
// - Program write: cmd, addr, size, data
// - Program write needs unlocked flash controller
// - Memory writes dropped unless halted, unlocked
// - Program read returns FFh when blocked
// - Data write: cmd, addr, size, data
// - Data read FFh only when running
// - CRC-16 over program memory, inverted
// - CRC sent high first; FFFFh when running
// - Step one instruction when halted, unlocked
// - Stuff opcode, rest from program memory
// - Execute host-sent instruction of 1-3 bytes
// - Baud reload returned high byte first
// - Halt bit stops CPU fetching
// - Break opcode is no-op unless enabled
// - Break halts; spin bit is not writable, stays 0, never spins
// - Ack byte FFh on break, bit clears
// - PC match break; counter holds meanwhile
// - Zero count break; counter kept on resume
// - Reset bit resets system, self-clears
// - Status: idle, low-power halt, lock
// - Baud reload is clock/baud times eight
`timescale 1ns/100ps
`default_nettype none
module debug_command_engine (
  input wire sys_clk,
  input wire nrst,
  input wire rx_valid,
  input wire [7:0] rx_data,
  output wire tx_valid,
  input wire tx_ready,
  output wire [7:0] tx_data,
  input wire [11:0] baud_reload,
  input wire readout_lock_pin,
  input wire flash_unlocked_pin,
  input wire lowpower_halt_pin,
  input wire break_decoded,
  input wire [15:0] cpu_pc,
  input wire cpu_running,
  input wire reset_done,
  output reg debug_halt,
  output reg break_spin,
  output reg system_reset,
  output reg mem_req,
  output reg mem_we,
  output reg [1:0] mem_space,
  output reg [15:0] mem_addr,
  output reg [7:0] mem_wdata,
  input wire mem_ack,
  input wire [7:0] mem_rdata,
  output reg instr_req,
  output reg [1:0] instr_kind,
  output reg [7:0] instr_byte,
  output reg instr_byte_valid,
  input wire instr_done
);
  `include "debug_engine_map.vh"
  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  wire lock_on;
  wire flash_ok;
  wire lowpwr;
  assign lock_on = sync_b[0];
  assign flash_ok = sync_b[1];
  assign lowpwr = sync_b[2];
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 3'b000;
      sync_b <= 3'b000;
    end else begin
      sync_a <= {lowpower_halt_pin, flash_unlocked_pin, readout_lock_pin};
      sync_b <= sync_a;
    end
  end
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function [15:0] crc_step;
    input [15:0] crc;
    input [7:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0] ^ data[i])
          c = (c >> 1) ^ `CRC_POLY_REFL;
        else
          c = c >> 1;
      end
      crc_step = c;
    end
  endfunction
  function [2:0] instr_len;
    input [7:0] op;
    begin
      case (op[3:0])
        4'hF, 4'hE, 4'hC, 4'hA, 4'hB, 4'h8, 4'h9: instr_len = 3'd2;
        4'hD: instr_len = 3'd3;
        4'h0, 4'h1: instr_len = (op[7:4] == 4'h0) ? 3'd1 : 3'd2;
        default: instr_len = 3'd3;
      endcase
    end
  endfunction
  // ------------------------------------------------------------
  // Control, status and counter
  // ------------------------------------------------------------
  reg [7:0] debug_control_reg;
  reg [15:0] debug_down_counter;
  reg break_seen;
  wire [7:0] debug_status_reg;
  assign debug_status_reg = {break_seen | debug_control_reg[`CTL_HALT], lowpwr, lock_on,
    5'b00000};
  wire halted;
  assign halted = debug_control_reg[`CTL_HALT];
  wire brk_hit;
  assign brk_hit = break_decoded && debug_control_reg[`CTL_BRK_EN];
  wire pc_hit;
  assign pc_hit = debug_control_reg[`CTL_PC_BRK] && cpu_running
    && (cpu_pc == debug_down_counter);
  wire zero_hit;
  assign zero_hit = debug_control_reg[`CTL_ZERO_BRK] && cpu_running
    && !debug_control_reg[`CTL_PC_BRK] && (debug_down_counter == 16'h0001);
  wire any_break;
  assign any_break = brk_hit || pc_hit || zero_hit;
  // ------------------------------------------------------------
  // Command sequencer
  // ------------------------------------------------------------
  localparam ST_CMD = 4'd0;
  localparam ST_ARG = 4'd1;
  localparam ST_WDATA = 4'd2;
  localparam ST_RDATA = 4'd3;
  localparam ST_RWAIT = 4'd4;
  localparam ST_CRC = 4'd5;
  localparam ST_SEND2 = 4'd6;
  localparam ST_INSTR = 4'd7;
  localparam ST_IWAIT = 4'd8;
  localparam ST_WWAIT = 4'd9;
  reg [3:0] state;
  reg [7:0] cmd;
  reg [2:0] arg_idx;
  reg [2:0] arg_need;
  reg [15:0] addr;
  reg [16:0] remain;
  reg [15:0] word_out;
  reg [15:0] crc;
  reg [2:0] ibytes;
  reg ack_pending;
  reg tx_push;
  reg [7:0] tx_byte;
  wire buf_ready;
  wire ok_rw;
  assign ok_rw = halted && !lock_on;
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      debug_control_reg <= `CTL_RESET_VAL;
      debug_down_counter <= 16'h0000;
      break_seen <= 1'b0;
      debug_halt <= 1'b0;
      break_spin <= 1'b0;
      system_reset <= 1'b0;
      state <= ST_CMD;
      cmd <= 8'h00;
      arg_idx <= 3'd0;
      arg_need <= 3'd0;
      addr <= 16'h0000;
      remain <= 17'd0;
      word_out <= 16'h0000;
      crc <= `CRC_PRESET;
      ibytes <= 3'd0;
      ack_pending <= 1'b0;
      tx_push <= 1'b0;
      tx_byte <= 8'h00;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_space <= 2'd0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
      instr_req <= 1'b0;
      instr_kind <= 2'd0;
      instr_byte <= 8'h00;
      instr_byte_valid <= 1'b0;
    end else begin
      if (tx_push && buf_ready)
        tx_push <= 1'b0;
      instr_byte_valid <= 1'b0;
      debug_halt <= debug_control_reg[`CTL_HALT];
      break_spin <= brk_hit && debug_control_reg[`CTL_SPIN];
      // Counter counts cycles only while the CPU runs and no PC match is armed
      if (cpu_running && !debug_control_reg[`CTL_PC_BRK])
        debug_down_counter <= debug_down_counter - 16'h0001;
      if (brk_hit)
        break_seen <= 1'b1;
      if ((brk_hit && !debug_control_reg[`CTL_SPIN]) || pc_hit || zero_hit)
        debug_control_reg[`CTL_HALT] <= 1'b1;
      if (any_break && debug_control_reg[`CTL_ACK_EN])
        ack_pending <= 1'b1;
      if (reset_done)
        debug_control_reg[`CTL_RESET] <= 1'b0;
      system_reset <= debug_control_reg[`CTL_RESET];
      if (ack_pending && state == ST_CMD && !tx_push) begin
        tx_push <= 1'b1;
        tx_byte <= `ACK_BYTE;
        ack_pending <= 1'b0;
        debug_control_reg[`CTL_ACK_EN] <= 1'b0;
      end
      case (state)
        ST_CMD: begin
          if (rx_valid && !ack_pending) begin
            cmd <= rx_data;
            arg_idx <= 3'd0;
            remain <= 17'd0;
            case (rx_data)
              `CMD_WR_CNTR, `CMD_RD_BAUD: begin
                arg_need <= 3'd2;
                state <= (rx_data == `CMD_RD_BAUD) ? ST_SEND2 : ST_ARG;
                word_out <= {4'h0, baud_reload};
              end
              `CMD_WR_CTRL, `CMD_STUFF, `CMD_EXEC: begin
                arg_need <= 3'd1;
                state <= ST_ARG;
              end
              `CMD_RD_STAT, `CMD_RD_CTRL: begin
                tx_push <= 1'b1;
                tx_byte <= (rx_data == `CMD_RD_STAT) ? debug_status_reg : debug_control_reg;
              end
              `CMD_WR_REG, `CMD_RD_REG: begin
                arg_need <= 3'd3;
                state <= ST_ARG;
              end
              `CMD_WR_PMEM, `CMD_RD_PMEM, `CMD_WR_DMEM, `CMD_RD_DMEM: begin
                arg_need <= 3'd4;
                state <= ST_ARG;
              end
              `CMD_CRC: begin
                crc <= `CRC_PRESET;
                addr <= 16'h0000;
                state <= halted ? ST_CRC : ST_SEND2;
                word_out <= 16'hFFFF;
              end
              `CMD_STEP: begin
                if (ok_rw) begin
                  instr_req <= 1'b1;
                  instr_kind <= 2'd0;
                  state <= ST_IWAIT;
                end
              end
              default: state <= ST_CMD;
            endcase
          end
        end
        ST_ARG: begin
          if (rx_valid) begin
            arg_idx <= arg_idx + 3'd1;
            if (cmd == `CMD_WR_REG || cmd == `CMD_RD_REG) begin
              if (arg_idx == 3'd0)
                addr[15:8] <= {4'h0, rx_data[3:0]};
              else if (arg_idx == 3'd1)
                addr[7:0] <= rx_data;
              else
                remain <= (rx_data == 8'h00) ? 17'd256 : {9'd0, rx_data};
            end else if (arg_idx == 3'd0) begin
              addr[15:8] <= rx_data;
              remain[15:8] <= rx_data;
            end else if (arg_idx == 3'd1) begin
              addr[7:0] <= rx_data;
            end else if (arg_idx == 3'd2) begin
              remain[15:8] <= rx_data;
            end else begin
              remain <= ({remain[15:8], rx_data} == 16'h0000) ? 17'h10000
                : {1'b0, remain[15:8], rx_data};
            end
            if (arg_idx + 3'd1 == arg_need) begin
              if (cmd == `CMD_WR_CNTR) begin
                if (halted)
                  debug_down_counter <= {addr[15:8], rx_data};
                state <= ST_CMD;
              end else if (cmd == `CMD_WR_CTRL) begin
                debug_control_reg <= {rx_data[7:5], debug_control_reg[`CTL_SPIN],
                  rx_data[3:2], 1'b0, rx_data[0]};
                break_seen <= 1'b0;
                state <= ST_CMD;
              end else if (cmd == `CMD_STUFF || cmd == `CMD_EXEC) begin
                instr_byte <= rx_data;
                instr_byte_valid <= ok_rw;
                instr_kind <= (cmd == `CMD_STUFF) ? 2'd1 : 2'd2;
                // A long execute asks for the CPU only once every byte is in
                if (ok_rw && (cmd == `CMD_STUFF || instr_len(rx_data) == 3'd1))
                  instr_req <= 1'b1;
                ibytes <= (cmd == `CMD_EXEC) ? instr_len(rx_data) - 3'd1 : 3'd0;
                state <= (cmd == `CMD_EXEC && instr_len(rx_data) != 3'd1) ? ST_INSTR
                  : (ok_rw ? ST_IWAIT : ST_CMD);
              end else if (cmd == `CMD_RD_REG || cmd == `CMD_RD_PMEM
                  || cmd == `CMD_RD_DMEM) begin
                state <= ST_RDATA;
              end else begin
                state <= ST_WDATA;
              end
            end
          end
        end
        ST_INSTR: begin
          if (rx_valid) begin
            instr_byte <= rx_data;
            instr_byte_valid <= ok_rw;
            ibytes <= ibytes - 3'd1;
            if (ibytes == 3'd1) begin
              instr_req <= ok_rw;
              state <= ok_rw ? ST_IWAIT : ST_CMD;
            end
          end
        end
        ST_IWAIT: begin
          if (instr_done) begin
            instr_req <= 1'b0;
            state <= ST_CMD;
          end
        end
        ST_WDATA: begin
          if (rx_valid) begin
            remain <= remain - 17'd1;
            addr <= addr + 16'h0001;
            mem_addr <= addr;
            mem_wdata <= rx_data;
            mem_space <= (cmd == `CMD_WR_REG) ? 2'd0 : (cmd == `CMD_WR_PMEM) ? 2'd1 : 2'd2;
            mem_we <= 1'b1;
            // Register writes outside on-chip RAM survive the lock
            if (halted && (!lock_on || (cmd == `CMD_WR_REG && addr[11:8] == 4'hF))
                && (cmd != `CMD_WR_PMEM || flash_ok)) begin
              mem_req <= 1'b1;
              state <= ST_WWAIT;
            end else if (remain == 17'd1) begin
              state <= ST_CMD;
            end
          end
        end
        ST_WWAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            state <= (remain == 17'd0) ? ST_CMD : ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (!tx_push) begin
            if (remain == 17'd0) begin
              state <= ST_CMD;
            end else if ((cmd == `CMD_RD_DMEM && !halted)
                || (cmd == `CMD_RD_PMEM && !ok_rw)
                || (cmd == `CMD_RD_REG && (!halted || (lock_on && addr[11:8] != 4'hF)))) begin
              tx_push <= 1'b1;
              tx_byte <= `FILL_BYTE;
              remain <= remain - 17'd1;
              addr <= addr + 16'h0001;
            end else begin
              mem_req <= 1'b1;
              mem_we <= 1'b0;
              mem_addr <= addr;
              mem_space <= (cmd == `CMD_RD_REG) ? 2'd0 : (cmd == `CMD_RD_PMEM) ? 2'd1 : 2'd2;
              state <= ST_RWAIT;
            end
          end
        end
        ST_RWAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            tx_push <= 1'b1;
            tx_byte <= mem_rdata;
            remain <= remain - 17'd1;
            addr <= addr + 16'h0001;
            state <= ST_RDATA;
          end
        end
        ST_CRC: begin
          if (!mem_req) begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_space <= 2'd1;
            mem_addr <= addr;
          end else if (mem_ack) begin
            mem_req <= 1'b0;
            crc <= crc_step(crc, mem_rdata);
            addr <= addr + 16'h0001;
            if (addr == `PMEM_LAST) begin
              word_out <= ~crc_step(crc, mem_rdata);
              state <= ST_SEND2;
            end
          end
        end
        ST_SEND2: begin
          if (!tx_push) begin
            tx_push <= 1'b1;
            arg_idx <= arg_idx + 3'd1;
            tx_byte <= (arg_idx == 3'd0) ? word_out[15:8] : word_out[7:0];
            if (arg_idx == 3'd1)
              state <= ST_CMD;
          end
        end
        default: state <= ST_CMD;
      endcase
    end
  end
  // ------------------------------------------------------------
  // Transmit buffer
  // ------------------------------------------------------------
  byte_buffer tx_buf (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .in_valid(tx_push),
    .in_ready(buf_ready),
    .in_data(tx_byte),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );
endmodule
`default_nettype wire

// file: debug_engine_properties.sv
`timescale 1ns/100ps
`default_nettype none
module debug_engine_properties (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [7:0] tx_data,
  input wire logic readout_lock_pin,
  input wire logic flash_unlocked_pin,
  input wire logic reset_done,
  input wire logic debug_halt,
  input wire logic system_reset,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [1:0] mem_space,
  input wire logic [15:0] mem_addr,
  input wire logic mem_ack,
  input wire logic instr_req,
  input wire logic [1:0] instr_kind,
  input wire logic instr_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  a_tx_byte_held:
    assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("tx byte changed before accept");
  a_mem_req_held:
    assert property (mem_req && !mem_ack |=> mem_req && $stable({mem_we, mem_space, mem_addr}))
    else $error("memory request changed before ack");
  a_instr_req_held:
    assert property (instr_req && !instr_done |=> instr_req && $stable(instr_kind))
    else $error("instruction request changed before done");
  a_write_when_halted:
    assert property (mem_req && mem_we |-> debug_halt)
    else $error("memory write while running");
  a_write_lock_clear:
    assert property (mem_req && mem_we && mem_space != 2'd0 |-> !$past(readout_lock_pin, 3))
    else $error("memory write under readout lock");
  a_prog_write_unlocked:
    assert property (mem_req && mem_we && mem_space == 2'd1 |-> $past(flash_unlocked_pin, 3))
    else $error("program write with flash locked");
  a_step_when_halted:
    assert property ($rose(instr_req) |-> debug_halt && !$past(readout_lock_pin, 3))
    else $error("instruction issued while running or locked");
  a_reset_self_clears:
    assert property (system_reset && reset_done |-> ##[1:2] !system_reset)
    else $error("reset bit did not clear");
  a_space_legal:
    assert property (mem_req |-> mem_space != 2'd3)
    else $error("illegal memory space");
  cover property (tx_valid && tx_ready);
  cover property (mem_req && mem_we && mem_ack);
  cover property (instr_req && instr_done);
endmodule
bind debug_command_engine debug_engine_properties debug_engine_properties_i (
  .sys_clk(sys_clk), .nrst(nrst), .tx_valid(tx_valid), .tx_ready(tx_ready),
  .tx_data(tx_data), .readout_lock_pin(readout_lock_pin),
  .flash_unlocked_pin(flash_unlocked_pin), .reset_done(reset_done),
  .debug_halt(debug_halt), .system_reset(system_reset), .mem_req(mem_req),
  .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr), .mem_ack(mem_ack),
  .instr_req(instr_req), .instr_kind(instr_kind), .instr_done(instr_done)
);
`default_nettype wire

// file: host_debugger_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_debugger_model (
  input wire logic sys_clk,
  output var logic tx_ready,
  output var logic rx_valid,
  output var logic [7:0] rx_data
);
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
  end
  // ----
  // Receive side stalls at random
  // ----
  always @(negedge sys_clk) tx_ready <= ($urandom % 3) != 0;
  // One byte, then a gap so the engine is never busy when the next lands
  task automatic send(input logic [7:0] b);
    @(negedge sys_clk);
    rx_valid <= 1'b1;
    rx_data <= b;
    @(negedge sys_clk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    repeat (6) @(negedge sys_clk);
  endtask
  // Memory command: address and size high byte first
  task automatic cmd_mem(input logic [7:0] op, input logic [15:0] a, input logic [15:0] n);
    send(op);
    send(a[15:8]);
    send(a[7:0]);
    send(n[15:8]);
    send(n[7:0]);
  endtask
endmodule
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic sys_clk, nrst, break_decoded, reset_done, mem_ack, instr_done, cpu_running;
  logic readout_lock_pin, flash_unlocked_pin, lowpower_halt_pin;
  logic [11:0] baud_reload;
  logic [15:0] cpu_pc, a;
  logic [7:0] mem_rdata;
  wire logic rx_valid, tx_valid, tx_ready, debug_halt, break_spin, system_reset;
  wire logic mem_req, mem_we, instr_req, instr_byte_valid;
  wire logic [1:0] mem_space, instr_kind;
  wire logic [15:0] mem_addr;
  wire logic [7:0] rx_data, tx_data, mem_wdata, instr_byte;
  logic [15:0] exp_q[$];
  logic [15:0] e;
  logic [25:0] w;
  logic [25:0] wq[$];
  logic [7:0] iq[$];
  logic [1:0] kq[$];
  int num_errors = 0, samples_checked = 0, cycles = 0, n_wr = 0, n_ins = 0;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  debug_command_engine debug_command_engine_i (.sys_clk(sys_clk), .nrst(nrst),
    .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_data(tx_data), .baud_reload(baud_reload), .readout_lock_pin(readout_lock_pin),
    .flash_unlocked_pin(flash_unlocked_pin), .lowpower_halt_pin(lowpower_halt_pin),
    .break_decoded(break_decoded), .cpu_pc(cpu_pc), .cpu_running(cpu_running),
    .reset_done(reset_done), .debug_halt(debug_halt), .break_spin(break_spin),
    .system_reset(system_reset), .mem_req(mem_req), .mem_we(mem_we),
    .mem_space(mem_space), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .instr_req(instr_req),
    .instr_kind(instr_kind), .instr_byte(instr_byte),
    .instr_byte_valid(instr_byte_valid), .instr_done(instr_done));
  host_debugger_model host_debugger_model_i (.sys_clk(sys_clk), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data));
  // ----
  // Memory, CPU and hang guard
  // ----
  always @(negedge sys_clk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= mem_addr[7:0] ^ 8'h5A;
    instr_done <= instr_req && !instr_done;
    cpu_pc <= 16'($urandom);
    cpu_running <= !debug_halt;
    if (mem_req && !mem_ack && mem_we) begin
      w = wq.pop_front();
      n_wr++;
      chk(mem_addr, w[23:8]);
      chk({6'h00, mem_space, mem_wdata}, {6'h00, w[25:24], w[7:0]});
    end
    if (instr_req && !instr_done) begin
      n_ins++;
      chk({14'h0000, instr_kind}, {14'h0000, kq.pop_front()});
    end
    if (instr_byte_valid) chk({8'h00, instr_byte}, {8'h00, iq.pop_front()});
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    samples_checked++;
    if (got !== want) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  // ----
  // Scoreboard on accepted tx bytes
  // ----
  always @(posedge sys_clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (exp_q.size() == 0) e = {8'hFF, ~tx_data};
      else e = exp_q.pop_front();
      chk({8'h00, tx_data & e[15:8]}, {8'h00, e[7:0] & e[15:8]});
    end
  end
  task automatic ex(input logic [7:0] v, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, v});
  endtask
  task automatic s(input logic [7:0] b);
    host_debugger_model_i.send(b);
  endtask
  task automatic mc(input logic [7:0] op, input logic [15:0] n);
    host_debugger_model_i.cmd_mem(op, a, n);
  endtask
  task automatic settle;
    int k = 0;
    while (exp_q.size() != 0 && k < 400) begin
      @(negedge sys_clk);
      k++;
    end
    repeat (12) @(negedge sys_clk);
  endtask
  task automatic break_opcode;
    break_decoded = 1'b1;
    @(negedge sys_clk);
    break_decoded = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic test_done;
    if (num_errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(32'hC156));
    {nrst, break_decoded, reset_done} = 3'h0;
    {readout_lock_pin, flash_unlocked_pin, lowpower_halt_pin} = 3'h0;
    baud_reload = 12'($urandom);
    a = 16'($urandom);
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    nrst = 1'b1;
    repeat (4) @(negedge sys_clk);
    ex(8'h00); s(8'h05);
    ex(8'h00); s(8'h02);
    ex({4'h0, baud_reload[11:8]}, 8'h0F); ex(baud_reload[7:0]); s(8'h1B);
    settle();
    ex(8'hFF); ex(8'hFF); mc(8'h0D, 16'h0002);
    settle();
    ex(8'hFF); ex(8'hFF); s(8'h0E);
    settle();
    mc(8'h0C, 16'h0001); s(8'h3C);
    s(8'h10);
    settle();
    chk(16'(n_wr + n_ins), 16'h0000);
    s(8'h04); s(8'h81);
    chk({15'h0, system_reset}, 16'h0001);
    reset_done = 1'b1;
    @(negedge sys_clk);
    reset_done = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({15'h0, system_reset}, 16'h0000);
    chk({15'h0, debug_halt}, 16'h0001);
    ex(8'h80); s(8'h05);
    ex(8'h80); s(8'h02);
    settle();
    for (int i = 0; i < 3; i++) ex(8'(a + i) ^ 8'h5A);
    mc(8'h0B, 16'h0003);
    settle();
    wq.push_back({2'd2, a, 8'h11});
    wq.push_back({2'd2, a + 16'd1, 8'h22});
    mc(8'h0C, 16'h0002); s(8'h11); s(8'h22);
    mc(8'h0A, 16'h0001); s(8'h33);
    settle();
    chk(16'(n_wr), 16'h0002);
    flash_unlocked_pin = 1'b1;
    wq.push_back({2'd1, a, 8'h44});
    mc(8'h0A, 16'h0001); s(8'h44);
    kq.push_back(2'd0);
    kq.push_back(2'd1);
    kq.push_back(2'd2);
    iq.push_back(8'h9C);
    iq.push_back(8'hB8);
    iq.push_back(8'h5E);
    s(8'h10); s(8'h11); s(8'h9C);
    s(8'h12); s(8'hB8); s(8'h5E);
    settle();
    chk(16'(n_wr), 16'h0003);
    chk(16'(n_ins), 16'h0003);
    readout_lock_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    ex(8'hA0); s(8'h02);
    ex(8'hFF); mc(8'h0B, 16'h0001);
    settle();
    ex(a[7:0] ^ 8'h5A); mc(8'h0D, 16'h0001);
    settle();
    ex(8'hFF); s(8'h09); s(8'h00); s(8'h10); s(8'h01);
    settle();
    mc(8'h0C, 16'h0001); s(8'h55);
    s(8'h10);
    settle();
    chk(16'(n_wr + n_ins), 16'h0006);
    readout_lock_pin = 1'b0;
    s(8'h04); s(8'h70);
    chk({15'h0, debug_halt}, 16'h0000);
    ex(8'hFF);
    break_opcode();
    chk({15'h0, debug_halt}, 16'h0001);
    chk({15'h0, break_spin}, 16'h0000);
    settle();
    ex(8'hC0); s(8'h05);
    settle();
    s(8'h01); s(8'h00); s(8'h40);
    s(8'h04); s(8'h04);
    chk({15'h0, debug_halt}, 16'h0000);
    repeat (80) @(negedge sys_clk);
    chk({15'h0, debug_halt}, 16'h0001);
    s(8'h04); s(8'h00);
    break_opcode();
    chk({15'h0, debug_halt}, 16'h0000);
    lowpower_halt_pin = 1'b1;
    repeat (4) @(negedge sys_clk);
    ex(8'h40); s(8'h02);
    settle();
    chk(16'(wq.size() + iq.size() + kq.size()), 16'h0000);
    test_done();
  end
endmodule
`default_nettype wire
